//--- common/aar_consts.svh
// register indices, field positions, reset values of the advertisement bank
`ifndef AAR_CONSTS_SVH
`define AAR_CONSTS_SVH

// register indices; the byte address is four times the index
`define AAR_IDX_CTL 14'h0200
`define AAR_IDX_LOW 14'h0202
`define AAR_IDX_MID 14'h0203
`define AAR_IDX_HIGH 14'h0204

// low word fields
`define AAR_LOW_NP 15
`define AAR_LOW_ACK 14
`define AAR_LOW_RF 13
`define AAR_LOW_FORCE 12
`define AAR_LOW_PAUSE_HI 11
`define AAR_LOW_PAUSE_LO 10
`define AAR_SELECTOR 5'h01

// middle word fields
`define AAR_MID_B10L 14
`define AAR_MID_LEADER 4

// high word fields
`define AAR_HIGH_TXABL 13
`define AAR_HIGH_TXREQ 12

// control word fields
`define AAR_CTL_EN 12
`define AAR_CTL_RESTART 9

// reset values
`define AAR_LOW_RST 16'h0001
`define AAR_MID_RST 16'h4000
`define AAR_HIGH_RST 16'h0000
`define AAR_CTL_RST 16'h1000
`define AAR_PAGE_RST 48'h0000_4000_0001

`endif

//--- common/aar_pkg.sv
// types shared by the advertisement register bank
package aar_pkg;
  typedef logic [15:0] aar_word_t;
  typedef logic [47:0] aar_page_t;
  typedef enum logic [1:0] {
    AAR_RS_IDLE = 2'b01,
    AAR_RS_PEND = 2'b10
  } aar_rst_state_t;
endpackage

//--- rtl/aar_page_snap.sv
// holding register for the page handed to the negotiation engine
`timescale 1ns/1ps
module aar_page_snap #(
  parameter int W = 48,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] din,
  output logic [W-1:0] q
);
  import aar_pkg::*;

  // software edits stay invisible on the link until the next load
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= RST_VAL;
    end
    else if (load)
    begin
      q <= din;
    end
  end
endmodule

//--- rtl/aar_restart_ctl.sv
// self-clearing restart request towards the negotiation engine
`timescale 1ns/1ps
module aar_restart_ctl (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic restartWr,
  input wire logic negStarted,
  output logic pending
);
  import aar_pkg::*;

  aar_rst_state_t state_q;
  aar_rst_state_t state_d;

  // a new write in the cycle the engine starts keeps the request alive
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      AAR_RS_IDLE:
      begin
        if (restartWr)
          state_d = AAR_RS_PEND;
      end
      AAR_RS_PEND:
      begin
        if (negStarted && !restartWr)
          state_d = AAR_RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= AAR_RS_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign pending = (state_q == AAR_RS_PEND);
endmodule

//--- rtl/aar_advert_regs.sv
// autonegotiation advertisement register bank with wishbone slave
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "aar_consts.svh"
module aar_advert_regs (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic strapLeader,
  input wire logic strapTxHiAbl,
  input wire logic strapTxHiReq,
  input wire logic codewordRx,
  input wire logic negStarted,
  output logic negStartReq,
  output logic negEnable,
  output aar_pkg::aar_page_t advertPage
);
  import aar_pkg::*;

  localparam aar_word_t LOW_RST = `AAR_LOW_RST;
  localparam aar_word_t MID_RST = `AAR_MID_RST;
  localparam aar_word_t HIGH_RST = `AAR_HIGH_RST;
  localparam aar_word_t CTL_RST = `AAR_CTL_RST;
  localparam aar_page_t PAGE_RST = `AAR_PAGE_RST;

  // ********************************************************
  // wishbone slave
  // ********************************************************
  logic wbReq;
  logic wbDone;
  logic selCtl;
  logic selLow;
  logic selMid;
  logic selHigh;
  logic wrCtl;
  logic wrLow;
  logic wrMid;
  logic wrHigh;
  aar_word_t rdWord;

  assign wbReq = wb_cyc_i && wb_stb_i;
  // the write lands on the edge at which the master sees ack
  assign wbDone = wbReq && wb_ack_o;
  assign selCtl = (wb_adr_i[15:2] == `AAR_IDX_CTL);
  assign selLow = (wb_adr_i[15:2] == `AAR_IDX_LOW);
  assign selMid = (wb_adr_i[15:2] == `AAR_IDX_MID);
  assign selHigh = (wb_adr_i[15:2] == `AAR_IDX_HIGH);
  assign wrCtl = wbDone && wb_we_i && selCtl;
  assign wrLow = wbDone && wb_we_i && selLow;
  assign wrMid = wbDone && wb_we_i && selMid;
  assign wrHigh = wbDone && wb_we_i && selHigh;

  // ack for one cycle per request, one cycle after it appears
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wbReq && !wb_ack_o;
    end
  end

  // read data taken with the rising ack; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (wbReq && !wb_ack_o)
    begin
      wb_dat_o <= {16'h0000, rdWord};
    end
  end

  // ********************************************************
  // strap capture
  // ********************************************************
  logic strapDone_q;
  logic strapFresh_q;

  // straps are caught after release, never inside the reset branch
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strapDone_q <= 1'b0;
      strapFresh_q <= 1'b0;
    end
    else
    begin
      strapDone_q <= 1'b1;
      strapFresh_q <= !strapDone_q;
    end
  end

  // ********************************************************
  // advertisement fields
  // ********************************************************
  logic npQ;
  logic ackQ;
  logic rfQ;
  logic forceQ;
  logic [1:0] pauseQ;
  logic b10lQ;
  logic leaderQ;
  logic txAblQ;
  logic txReqQ;
  logic enQ;
  aar_word_t lowWord;
  aar_word_t midWord;
  aar_word_t highWord;
  aar_word_t wrData;

  // bytes not selected keep the value passed in as old, which is zero for the control word
  function automatic aar_word_t laneMerge(aar_word_t old, aar_word_t nw,
                                          logic [1:0] sel);
    laneMerge = {sel[1] ? nw[15:8] : old[15:8],
                 sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  always_comb
  begin
    lowWord = 16'h0000;
    lowWord[`AAR_LOW_NP] = npQ;
    lowWord[`AAR_LOW_ACK] = ackQ;
    lowWord[`AAR_LOW_RF] = rfQ;
    lowWord[`AAR_LOW_FORCE] = forceQ;
    lowWord[`AAR_LOW_PAUSE_HI:`AAR_LOW_PAUSE_LO] = pauseQ;
    lowWord[4:0] = `AAR_SELECTOR;
  end

  always_comb
  begin
    midWord = 16'h0000;
    midWord[`AAR_MID_B10L] = b10lQ;
    midWord[`AAR_MID_LEADER] = leaderQ;
  end

  always_comb
  begin
    highWord = 16'h0000;
    highWord[`AAR_HIGH_TXABL] = txAblQ;
    highWord[`AAR_HIGH_TXREQ] = txReqQ;
  end

  always_comb
  begin
    wrData = 16'h0000;
    if (selLow)
      wrData = laneMerge(lowWord, wb_dat_i[15:0], wb_sel_i[1:0]);
    else if (selMid)
      wrData = laneMerge(midWord, wb_dat_i[15:0], wb_sel_i[1:0]);
    else if (selHigh)
      wrData = laneMerge(highWord, wb_dat_i[15:0], wb_sel_i[1:0]);
    else if (selCtl)
      wrData = laneMerge(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      npQ <= LOW_RST[`AAR_LOW_NP];
      rfQ <= LOW_RST[`AAR_LOW_RF];
      forceQ <= LOW_RST[`AAR_LOW_FORCE];
      pauseQ <= LOW_RST[`AAR_LOW_PAUSE_HI:`AAR_LOW_PAUSE_LO];
    end
    else if (wrLow)
    begin
      npQ <= wrData[`AAR_LOW_NP];
      rfQ <= wrData[`AAR_LOW_RF];
      forceQ <= wrData[`AAR_LOW_FORCE];
      pauseQ <= wrData[`AAR_LOW_PAUSE_HI:`AAR_LOW_PAUSE_LO];
    end
  end

  // codeword seen wins over the clear from a fresh start
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ackQ <= LOW_RST[`AAR_LOW_ACK];
    end
    else if (codewordRx)
    begin
      ackQ <= 1'b1;
    end
    else if (negStarted)
    begin
      ackQ <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      b10lQ <= MID_RST[`AAR_MID_B10L];
      leaderQ <= MID_RST[`AAR_MID_LEADER];
    end
    else if (!strapDone_q)
    begin
      leaderQ <= strapLeader;
    end
    else if (wrMid)
    begin
      b10lQ <= wrData[`AAR_MID_B10L];
      leaderQ <= wrData[`AAR_MID_LEADER];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txAblQ <= HIGH_RST[`AAR_HIGH_TXABL];
      txReqQ <= HIGH_RST[`AAR_HIGH_TXREQ];
    end
    else if (!strapDone_q)
    begin
      txAblQ <= strapTxHiAbl;
      txReqQ <= strapTxHiReq;
    end
    else if (wrHigh)
    begin
      txAblQ <= wrData[`AAR_HIGH_TXABL];
      txReqQ <= wrData[`AAR_HIGH_TXREQ];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enQ <= CTL_RST[`AAR_CTL_EN];
    end
    else if (wrCtl)
    begin
      enQ <= wrData[`AAR_CTL_EN];
    end
  end

  // ********************************************************
  // restart and page hand-over
  // ********************************************************
  logic restartPend;
  logic restartWr;
  logic snapLoad;
  aar_page_t pageLive;
  aar_page_t pageSnap;

  assign restartWr = wrCtl && wrData[`AAR_CTL_RESTART];

  aar_restart_ctl i_aar_restart_ctl (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .restartWr(restartWr),
    .negStarted(negStarted),
    .pending(restartPend)
  );

  assign negEnable = enQ;
  // disabled negotiation holds the request back rather than dropping it
  assign negStartReq = restartPend && enQ;

  assign pageLive = {highWord, midWord, lowWord};
  // strap values reach the engine once, right after capture
  assign snapLoad = negStarted || strapFresh_q;

  aar_page_snap #(
    .W(48),
    .RST_VAL(PAGE_RST)
  ) i_aar_page_snap (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(snapLoad),
    .din(pageLive),
    .q(pageSnap)
  );

  // the acknowledge bit is live protocol state, not a sampled setting
  always_comb
  begin
    advertPage = pageSnap;
    advertPage[`AAR_LOW_ACK] = ackQ;
  end

  always_comb
  begin
    rdWord = 16'h0000;
    if (selLow)
      rdWord = lowWord;
    else if (selMid)
      rdWord = midWord;
    else if (selHigh)
      rdWord = highWord;
    else if (selCtl)
    begin
      rdWord[`AAR_CTL_EN] = enQ;
      rdWord[`AAR_CTL_RESTART] = restartPend;
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence wbAsk;
    wbReq && !wb_ack_o;
  endsequence

  sequence wbAnswer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_wb_ack_timing: assert property (
    wbAsk |=> wbAnswer)
    else $error("ack not a single cycle one cycle after request");

  chk_np_write: assert property (
    wrLow && wb_sel_i[1] |=> npQ == $past(wb_dat_i[15]))
    else $error("next page request not written");

  chk_ack_set: assert property (
    codewordRx |=> ackQ && lowWord[14])
    else $error("acknowledge not set by codeword");

  chk_ack_readonly: assert property (
    wrLow && !codewordRx && !negStarted |=> $stable(ackQ))
    else $error("acknowledge changed by software");

  chk_low_fixed: assert property (
    wb_ack_o && selLow && !wb_we_i |-> wb_dat_o[9:0] == 10'h001)
    else $error("low word selector or reserved bits wrong");

  chk_mid_reserved: assert property (
    wb_ack_o && selMid && !wb_we_i |-> (wb_dat_o & 32'hffff_bfef) == 32'h0)
    else $error("middle word reserved bits not zero");

  chk_restart_hold: assert property (
    restartWr || (restartPend && !negStarted) |=> restartPend)
    else $error("restart request dropped before start");

  chk_restart_clear: assert property (
    restartPend && negStarted && !restartWr |=> !restartPend)
    else $error("restart bit not self cleared");

  chk_page_map: assert property (
    negStarted |=> advertPage[31:16] == $past(midWord) &&
                   advertPage[20] == $past(leaderQ))
    else $error("page not sampled from words at start");

  chk_page_stable: assert property (
    !snapLoad |=> advertPage[47:15] == $past(advertPage[47:15]))
    else $error("page changed outside a start");

  chk_b10l_reset: assert property (
    $rose(strapDone_q) |-> b10lQ && !npQ && !rfQ && pauseQ == 2'h0)
    else $error("field reset values wrong");
endmodule

//--- dv/aar_engine_model.sv
// negotiation engine stand-in that answers restart requests
`timescale 1ns/1ps
module aar_engine_model #(
  parameter int START_DLY = 20,
  parameter int CW_DLY = 10
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic negStartReq,
  output logic negStarted,
  output logic codewordRx
);
  int cnt_q;
  logic busy_q;
  // ****************************************
  // one start pulse, then one codeword pulse
  // ****************************************
  // no new request is looked at until the codeword is out, as a real
  // engine would not restart in mid exchange
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= 0;
      busy_q <= 1'b0;
      negStarted <= 1'b0;
      codewordRx <= 1'b0;
    end
    else
    begin
      negStarted <= 1'b0;
      codewordRx <= 1'b0;
      if (!busy_q)
      begin
        if (negStartReq)
        begin
          busy_q <= 1'b1;
          cnt_q <= 0;
        end
      end
      else
      begin
        cnt_q <= cnt_q + 1;
        if (cnt_q == START_DLY)
          negStarted <= 1'b1;
        if (cnt_q == START_DLY + CW_DLY)
        begin
          codewordRx <= 1'b1;
          busy_q <= 1'b0;
        end
      end
    end
  end
endmodule

//--- dv/tb_aar_advert_regs.sv
// self-checking bench for the advertisement register bank
`timescale 1ns/1ps
module tb_aar_advert_regs;
  import aar_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [15:0] wbAdr = 16'h0000;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic negStartReq;
  logic negEnable;
  logic negStarted;
  logic codewordRx;
  aar_page_t advertPage;
  logic [31:0] rd;
  logic [15:0] rowA;
  logic [3:0] rowS;
  logic [15:0] rowW;
  logic [15:0] rowE;
  logic strapLeader = 1'b1;
  int failures = 0;
  int nCompared = 0;
  int n;
  // ****************************************
  // rows: address, byte enables, write data, read back
  // ****************************************
  logic [51:0] rows [8] = '{
    {16'h0808, 4'h3, 16'hffff, 16'hbc01},
    {16'h0808, 4'h3, 16'h0000, 16'h0001},
    {16'h0808, 4'h3, 16'ha400, 16'ha401},
    {16'h0808, 4'h1, 16'hffff, 16'ha401},
    {16'h080c, 4'h3, 16'hffff, 16'h4010},
    {16'h080c, 4'h3, 16'h0000, 16'h0000},
    {16'h080c, 4'h1, 16'hffff, 16'h0010},
    {16'h0840, 4'h3, 16'hffff, 16'h0000}};

  always #5 clk_sys = ~clk_sys;

  aar_advert_regs i_aar_advert_regs (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb),
    .wb_we_i(wbWe),
    .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel),
    .wb_dat_i(wbDat),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .strapLeader(strapLeader),
    .strapTxHiAbl(1'b1),
    .strapTxHiReq(1'b0),
    .codewordRx(codewordRx),
    .negStarted(negStarted),
    .negStartReq(negStartReq),
    .negEnable(negEnable),
    .advertPage(advertPage)
  );

  aar_engine_model i_aar_engine_model (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .negStartReq(negStartReq),
    .negStarted(negStarted),
    .codewordRx(codewordRx)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; the gap comes from the edge waited before raising
  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [15:0] d, input logic [3:0] s);
    int k;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= s;
    wbDat <= {16'h0000, d};
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 40);
    rd = wb_dat_o;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (k >= 40)
    begin
      failures++;
      $display("mismatch at %0t: no bus answer", $time);
    end
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 16'h0000, 4'h3);
    chk(rd, e);
  endtask

  // cw picks the codeword pulse, otherwise the start pulse
  task automatic wait_hi(input logic cw);
    for (n = 0; n < 100 && (cw ? codewordRx : negStarted) !== 1'b1; n++)
      @(posedge clk_sys);
    if (n >= 100)
    begin
      failures++;
      $display("mismatch at %0t: no engine pulse", $time);
    end
    repeat (2) @(posedge clk_sys);
  endtask

  task stop_test;
    $display("compared %0d, failures %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // watchdog, well beyond the roughly 155 cycles the run needs
  // ****************************************
  initial
  begin
    #100000;
    failures++;
    stop_test;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clk_sys);
    chk({wb_ack_o, negEnable, negStartReq}, 3'b010);
    chk(advertPage, 48'h0000_4000_0001);
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdchk(16'h0808, 32'h0001);
    rdchk(16'h080c, 32'h4010);
    rdchk(16'h0810, 32'h2000);
    rdchk(16'h0800, 32'h1000);
    chk(advertPage, 48'h2000_4010_0001);
    foreach (rows[i])
    begin
      {rowA, rowS, rowW, rowE} = rows[i];
      wb(1'b1, rowA, rowW, rowS);
      rdchk(rowA, rowE);
    end
    // edits must not reach the engine before a restart
    chk(advertPage, 48'h2000_4010_0001);
    wb(1'b1, 16'h0810, 16'hffff, 4'h3);
    rdchk(16'h0810, 32'h3000);
    wb(1'b1, 16'h0800, 16'h1200, 4'h3);
    rdchk(16'h0800, 32'h1200);
    wait_hi(1'b0);
    chk(advertPage, 48'h3000_0010_a401);
    chk(negStartReq, 1'b0);
    rdchk(16'h0800, 32'h1000);
    wait_hi(1'b1);
    rdchk(16'h0808, 32'he401);
    chk(advertPage[14], 1'b1);
    wb(1'b1, 16'h0808, 16'h0000, 4'h3);
    rdchk(16'h0808, 32'h4001);
    // restart while disabled stays pending but silent
    wb(1'b1, 16'h0800, 16'h0200, 4'h3);
    repeat (4) @(posedge clk_sys);
    chk({negEnable, negStartReq}, 2'b00);
    rdchk(16'h0800, 32'h0200);
    wb(1'b1, 16'h0800, 16'h1000, 4'h3);
    repeat (2) @(posedge clk_sys);
    chk({negEnable, negStartReq}, 2'b11);
    // mid-run reset with the other strap level; no edit may survive it
    strapLeader <= 1'b0;
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({wb_ack_o, negEnable, negStartReq}, 3'b010);
    chk(advertPage, 48'h0000_4000_0001);
    arst_n <= 1'b1;
    rdchk(16'h0808, 32'h0001);
    rdchk(16'h080c, 32'h4000);
    rdchk(16'h0800, 32'h1000);
    chk(advertPage, 48'h2000_4000_0001);
    stop_test;
  end
endmodule
